// >>> pkg/ssb_pkg.sv
// shared constants and types for the burst-sequencing, sleep-capable sram block
// assumes a single 50 MHz clock and an AHB-Lite register port with word-sized registers
package ssb_pkg;

	////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLOCK_PERIOD_NS        = 20;
	// recovery after sleep is not given a figure; plain default
	localparam int SLEEP_RECOVERY_TIME_NS = 100;
	// least time: round up, never below one cycle
	localparam int SLEEP_RECOVERY_RAW     =
		(SLEEP_RECOVERY_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int SLEEP_RECOVERY_CYCLES  = (SLEEP_RECOVERY_RAW < 1) ? 1 : SLEEP_RECOVERY_RAW;
	// edges from sleep request high to sleep state
	localparam int SLEEP_ENTRY_CYCLES     = 2;
	localparam int RECOVERY_CNT_W         = 8;

	////////////////////////////////////////////////////////////////////////////
	// burst counter
	localparam int BURST_CNT_W = 2;
	localparam int BURST_LEN   = 4;

	////////////////////////////////////////////////////////////////////////////
	// register map (byte addresses)
	localparam logic [31:0] CTRL_OFFSET   = 32'h0000_0000;
	localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
	localparam int          REG_ADDR_W    = 12;

	// control fields
	localparam int         CTRL_FLOW_THROUGH_SELECT_BIT = 0;
	localparam int         CTRL_BURST_ORDER_SELECT_BIT  = 1;
	localparam int         CTRL_W                       = 2;
	// pipelined timing and linear order out of reset
	localparam logic [1:0] CTRL_RESET                   = 2'h1;

	// status fields
	localparam int STATUS_ASLEEP_BIT     = 0;
	localparam int STATUS_RECOVERING_BIT = 1;
	localparam int STATUS_COUNT_LSB      = 2;

	////////////////////////////////////////////////////////////////////////////
	// burst operation kind held across advance cycles
	typedef enum logic [1:0] {
		SSB_OP_NONE,
		SSB_OP_READ,
		SSB_OP_WRITE
	} ssb_op_e;

endpackage : ssb_pkg

// >>> rtl/ssb_burst_addr.sv
// two-bit burst address generator, linear or interleaved order
// assumes the caller blocks load and advance while the device sleeps
`timescale 1ns/1ns

module ssb_burst_addr
	import ssb_pkg::*;
(
	input  wire logic                   i_clock,
	input  wire logic                   i_sys_rst,
	input  wire logic                   i_load,
	input  wire logic                   i_advance,
	input  wire logic                   i_interleave,
	input  wire logic [BURST_CNT_W-1:0] i_start,
	output logic      [BURST_CNT_W-1:0] o_addr_lo,
	output logic      [BURST_CNT_W-1:0] o_count
);

	logic [BURST_CNT_W-1:0] start_reg;
	logic [BURST_CNT_W-1:0] count_reg;
	logic [BURST_CNT_W-1:0] count_next;
	logic [BURST_CNT_W-1:0] step_count;
	logic [BURST_CNT_W-1:0] seq_addr;

	////////////////////////////////////////////////////////////////////////////
	// address of the step being taken now
	assign step_count = count_reg + 2'h1;   // wraps after four, back to the start
	assign seq_addr   = i_interleave ? (start_reg ^ step_count) : (start_reg + step_count);
	assign o_addr_lo  = i_load ? i_start : seq_addr;
	assign o_count    = count_reg;

	assign count_next = i_load ? 2'h0 : (i_advance ? step_count : count_reg);

	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			start_reg <= 2'h0;
			count_reg <= 2'h0;
		end
		else
		begin
			start_reg <= i_load ? i_start : start_reg;
			count_reg <= count_next;
		end
	end

endmodule : ssb_burst_addr

// >>> rtl/ssb_top.sv
// synchronous sram core with burst addressing, flow-through or pipelined reads
// and a sleep mode; AHB-Lite slave for control and status
// assumes one clock, memory-side inputs synchronous except the sleep request
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns

module ssb_top
	import ssb_pkg::*;
#(
	parameter int ADDR_W = 4,
	parameter int DATA_W = 8
)
(
	input  wire logic              i_clock,
	input  wire logic              i_sys_rst,
	// ahb-lite register port
	input  wire logic              i_hsel,
	input  wire logic [31:0]       i_haddr,
	input  wire logic [1:0]        i_htrans,
	input  wire logic              i_hwrite,
	input  wire logic [2:0]        i_hsize,
	input  wire logic [31:0]       i_hwdata,
	input  wire logic              i_hready,
	output logic      [31:0]       o_hrdata,
	output logic                   o_hreadyout,
	output logic                   o_hresp,
	// memory side
	input  wire logic              i_sleep_request,
	input  wire logic              i_sram_select,
	input  wire logic              i_sram_write,
	input  wire logic              i_burst_advance,
	input  wire logic [ADDR_W-1:0] i_sram_addr,
	input  wire logic [DATA_W-1:0] i_sram_wdata,
	output logic      [DATA_W-1:0] o_sram_rdata,
	output logic                   o_sram_rdata_oe
);

	////////////////////////////////////////////////////////////////////////////
	// parameter checks
	generate
		if (ADDR_W < BURST_CNT_W + 1 || ADDR_W > 12 || DATA_W < 1 || DATA_W > 32)
		begin : g_bad_size
			$error("ssb_top: ADDR_W must be 3..12 and DATA_W 1..32");
		end
		if (SLEEP_RECOVERY_CYCLES >= (1 << RECOVERY_CNT_W))
		begin : g_bad_recovery
			$error("ssb_top: recovery count does not fit its counter");
		end
	endgenerate

	localparam int DEPTH = 1 << ADDR_W;
	localparam logic [RECOVERY_CNT_W-1:0] RECOVERY_LOAD = RECOVERY_CNT_W'(SLEEP_RECOVERY_CYCLES);

	// register decode shared by read and write paths
	function automatic logic [1:0] ssb_decode(input logic [31:0] addr);
		ssb_decode = {addr == STATUS_OFFSET, addr == CTRL_OFFSET};
	endfunction : ssb_decode

	////////////////////////////////////////////////////////////////////////////
	// declarations
	logic                      sleep_meta_reg;
	logic                      sleep_sync_reg;
	logic [RECOVERY_CNT_W-1:0] recovery_reg;
	logic [RECOVERY_CNT_W-1:0] recovery_next;
	logic [CTRL_W-1:0]         ctrl_reg;
	logic                      wr_pend_reg;
	logic [31:0]               wr_addr_reg;
	logic [31:0]               hrdata_reg;
	logic                      hreadyout_reg;
	logic                      hresp_reg;
	ssb_op_e                   op_reg;
	ssb_op_e                   op_next;
	logic [ADDR_W-1:0]         addr_hi_reg;
	logic [DATA_W-1:0]         mem_reg [DEPTH];
	logic [DATA_W-1:0]         pipe_data_reg;
	logic                      pipe_valid_reg;
	logic [DATA_W-1:0]         rdata_reg;
	logic                      rdata_oe_reg;

	wire                       asleep      = sleep_sync_reg;
	wire                       awake       = !sleep_sync_reg;
	wire                       recovering  = (recovery_reg != '0);
	wire                       flow_sel    = ctrl_reg[CTRL_FLOW_THROUGH_SELECT_BIT];
	wire                       order_sel   = ctrl_reg[CTRL_BURST_ORDER_SELECT_BIT];
	wire                       ahb_take    = i_hsel & i_hready & i_htrans[1];
	wire [1:0]                 rd_hit      = ssb_decode(i_haddr);
	wire [1:0]                 wr_hit      = ssb_decode(wr_addr_reg);
	logic [BURST_CNT_W-1:0]    burst_lo;
	logic [BURST_CNT_W-1:0]    burst_count;

	////////////////////////////////////////////////////////////////////////////
	// sleep request synchroniser and recovery timer
	// async request, two flops
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			sleep_meta_reg <= 1'b0;
			sleep_sync_reg <= 1'b0;
		end
		else
		begin
			sleep_meta_reg <= i_sleep_request;
			sleep_sync_reg <= sleep_meta_reg;
		end
	end

	assign recovery_next = asleep ? RECOVERY_LOAD :
		(recovering ? recovery_reg - 1'b1 : recovery_reg);

	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			recovery_reg <= '0;
		else
			recovery_reg <= recovery_next;
	end

	////////////////////////////////////////////////////////////////////////////
	// ahb-lite slave: zero wait states, always OKAY, unmapped reads return zero
	wire [31:0] status_word = {28'h0, burst_count, recovering, asleep};
	wire [31:0] ctrl_word   = {30'h0, ctrl_reg};
	wire [31:0] rd_word     = rd_hit[1] ? status_word : (rd_hit[0] ? ctrl_word : 32'h0);
	wire        ctrl_write  = wr_pend_reg & wr_hit[0];

	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			wr_pend_reg   <= 1'b0;
			wr_addr_reg   <= 32'h0;
			hrdata_reg    <= 32'h0;
			hreadyout_reg <= 1'b1;
			hresp_reg     <= 1'b0;
		end
		else
		begin
			wr_pend_reg   <= ahb_take & i_hwrite;
			wr_addr_reg   <= ahb_take ? i_haddr : wr_addr_reg;
			hrdata_reg    <= (ahb_take & !i_hwrite) ? rd_word : 32'h0;
			hreadyout_reg <= 1'b1;
			hresp_reg     <= 1'b0;
		end
	end

	// control is a software mode setting; changing it mid-burst is the user's risk
	// output-register and burst-order select
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			ctrl_reg <= CTRL_RESET;
		else if (ctrl_write)
			ctrl_reg <= i_hwdata[CTRL_W-1:0];
	end

	////////////////////////////////////////////////////////////////////////////
	// memory command decode, all gated off while asleep
	// inputs ignored asleep
	wire load_cmd = awake & !i_burst_advance & i_sram_select;
	wire desel    = awake & !i_burst_advance & !i_sram_select;
	wire adv_cmd  = awake & i_burst_advance & (op_reg != SSB_OP_NONE);
	// writes during recovery are dropped rather than risk corruption
	// no writes recovering
	wire wr_ok    = !recovering;
	wire acc_read = (load_cmd & !i_sram_write) | (adv_cmd & op_reg == SSB_OP_READ);
	wire acc_wr   = wr_ok & ((load_cmd & i_sram_write) | (adv_cmd & op_reg == SSB_OP_WRITE));

	assign op_next = load_cmd ? (i_sram_write ? SSB_OP_WRITE : SSB_OP_READ) :
		(desel ? SSB_OP_NONE : op_reg);

	// order select drives xor or add
	ssb_burst_addr u_burst (
		.i_clock      (i_clock),
		.i_sys_rst    (i_sys_rst),
		.i_load       (load_cmd),
		.i_advance    (adv_cmd),
		.i_interleave (order_sel),
		.i_start      (i_sram_addr[BURST_CNT_W-1:0]),
		.o_addr_lo    (burst_lo),
		.o_count      (burst_count)
	);

	wire [ADDR_W-1:0] acc_addr = {load_cmd ? i_sram_addr[ADDR_W-1:BURST_CNT_W]
		: addr_hi_reg[ADDR_W-1:BURST_CNT_W], burst_lo};

	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			op_reg      <= SSB_OP_NONE;
			addr_hi_reg <= '0;
		end
		else
		begin
			op_reg      <= op_next;
			addr_hi_reg <= load_cmd ? i_sram_addr : addr_hi_reg;
		end
	end

	// storage array, no reset so contents survive everything but power
	always_ff @(posedge i_clock)
	begin
		if (acc_wr)
			mem_reg[acc_addr] <= i_sram_wdata;
	end

	////////////////////////////////////////////////////////////////////////////
	// read data path: flow-through presents after one edge, pipelined after two
	// low is flow-through
	wire              flow_mode  = !flow_sel;
	wire [DATA_W-1:0] array_word = mem_reg[acc_addr];
	wire              oe_next    = awake & (flow_mode ? acc_read : pipe_valid_reg);
	wire [DATA_W-1:0] rdata_next = flow_mode ? array_word : pipe_data_reg;

	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			pipe_data_reg  <= '0;
			pipe_valid_reg <= 1'b0;
			rdata_reg      <= '0;
			rdata_oe_reg   <= 1'b0;
		end
		else
		begin
			pipe_data_reg  <= acc_read ? array_word : pipe_data_reg;
			pipe_valid_reg <= awake ? acc_read : pipe_valid_reg;
			rdata_reg      <= oe_next ? rdata_next : rdata_reg;
			rdata_oe_reg   <= oe_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs straight from flops
	assign o_hrdata        = hrdata_reg;
	assign o_hreadyout     = hreadyout_reg;
	assign o_hresp         = hresp_reg;
	assign o_sram_rdata    = rdata_reg;
	assign o_sram_rdata_oe = rdata_oe_reg;

endmodule : ssb_top

// >>> verification/ssb_ctrl_model.sv
// memory controller side: owns the sleep pin and gates writes
// assumes the bench reports when a command is on the pins
`timescale 1ns/1ns
module ssb_ctrl_model
	import ssb_pkg::*;
(
	input  wire logic i_clock,
	input  wire logic i_sys_rst,
	input  wire logic i_want_sleep,
	input  wire logic i_busy,
	input  wire logic i_write,
	output logic      o_sleep_request,
	output logic      o_write
);
	logic [RECOVERY_CNT_W-1:0] rec_reg;
	////////////////////////////////////////////////////////////////
	// follows the ask only when idle, else holds
	always_ff @(posedge i_clock or posedge i_sys_rst)
		if (i_sys_rst)
			o_sleep_request <= 1'b0;
		else if (!i_busy)
			o_sleep_request <= i_want_sleep;
	// recovery window, padded for the device's synchroniser
	always_ff @(posedge i_clock or posedge i_sys_rst)
		if (i_sys_rst)
			rec_reg <= '0;
		else if (o_sleep_request)
			rec_reg <= RECOVERY_CNT_W'(SLEEP_RECOVERY_CYCLES + SLEEP_ENTRY_CYCLES + 1);
		else if (rec_reg != '0)
			rec_reg <= rec_reg - 1'b1;
	assign o_write = i_write && (o_sleep_request || rec_reg == '0);
endmodule : ssb_ctrl_model

// >>> verification/ssb_top_bench.sv
// self-checking bench for the burst and sleep sram block
// assumes the controller model drives the sleep pin and write gate
`timescale 1ns/1ns
module ssb_top_bench
	import ssb_pkg::*;
;
	logic        clk = 0, rst = 1, hsel = 0, hwr = 0, sel = 0, wr = 0, burst_advance = 0, want = 0;
	logic [31:0] haddr = 0, hwdata = 0;
	logic [1:0]  htrans = 0, lo;
	logic [3:0]  addr = 0, st;
	logic [7:0]  wdata = 0, mem [16], q [$];
	wire  [31:0] hrdata;
	wire  [7:0]  rdata;
	wire         rdy, hresp, oe, zz, wr_pin;
	int          fails = 0, n_tests = 0, seed = 32'hba39;
	always #10 clk = ~clk;
	ssb_ctrl_model i_ssb_ctrl_model (.i_clock(clk), .i_sys_rst(rst), .i_want_sleep(want),
		.i_busy(sel | burst_advance), .i_write(wr), .o_sleep_request(zz), .o_write(wr_pin));
	ssb_top i_ssb_top (.i_clock(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwr), .i_hsize(3'h2), .i_hwdata(hwdata),
		.i_hready(rdy), .o_hrdata(hrdata), .o_hreadyout(rdy), .o_hresp(hresp),
		.i_sleep_request(zz), .i_sram_select(sel), .i_sram_write(wr_pin),
		.i_burst_advance(burst_advance), .i_sram_addr(addr), .i_sram_wdata(wdata),
		.o_sram_rdata(rdata), .o_sram_rdata_oe(oe));
	////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one memory read beat against its note
	task automatic chk_mem(input logic [7:0] got, exp);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_mem
	// bounded wait for ready at an edge
	task automatic wait_rdy();
		int k;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (rdy !== 1'b1 && k < 40);
		if (k >= 40)
		begin
			fails++;
			close_out();
		end
	endtask : wait_rdy
	task automatic ahb(input logic w, input logic [31:0] a, d, e, m);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwr <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		if (!w)
			chk(hrdata & m, e);
	endtask : ahb
	task automatic cyc(input logic s, w, v, input logic [3:0] a, input logic [7:0] d);
		sel <= s;
		wr <= w;
		burst_advance <= v;
		addr <= a;
		wdata <= d;
		@(posedge clk);
	endtask : cyc
	// each read beat takes the oldest note; an empty queue mismatches
	always @(posedge clk)
		if (!rst && oe === 1'b1)
			chk_mem(rdata, q.size() != 0 ? q.pop_front() : 8'hxx);
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		ahb(0, CTRL_OFFSET, 0, 32'h1, 32'hffffffff);
		ahb(0, 32'h10, 0, 0, 32'hffffffff);
		for (int i = 0; i < 16; i++)
		begin
			mem[i] = 8'($random(seed));
			// write bursts of four, linear from an aligned start
			cyc(1, 1, i[1:0] != 2'h0, i[3:0], mem[i]);
		end
		// all four mode pairs; fifth beat shows the wrap, junk upper bits
		for (int m = 0; m < 4; m++)
		begin
			repeat (3) cyc(0, 0, 0, 0, 0);
			ahb(1, CTRL_OFFSET, m, 0, 0);
			st = 4'($random(seed));
			for (int n = 0; n < 5; n++)
			begin
				lo = m[1] ? st[1:0] ^ n[1:0] : st[1:0] + n[1:0];
				q.push_back(mem[{st[3:2], lo}]);
				cyc(n == 0, 0, n != 0, n == 0 ? st : 4'($random(seed)), 8'h0);
			end
		end
		repeat (3) cyc(0, 0, 0, 0, 0);
		want <= 1'b1;
		repeat (5) @(posedge clk);
		ahb(0, STATUS_OFFSET, 0, 32'h1, 32'h1);
		cyc(1, 1, 0, 4'h5, ~mem[5]);
		cyc(1, 0, 0, 4'h6, 8'h0);
		cyc(0, 0, 0, 0, 0);
		want <= 1'b0;
		repeat (20) @(posedge clk);
		ahb(0, STATUS_OFFSET, 0, 0, 32'h3);
		q.push_back(mem[5]);
		cyc(1, 0, 0, 4'h5, 8'h0);
		cyc(0, 0, 0, 0, 0);
		// continue after a deselect must read nothing
		repeat (3) cyc(0, 0, 1, 4'h5, 8'h0);
		repeat (2) cyc(0, 0, 0, 0, 0);
		chk(q.size(), 0);
		close_out();
	end
endmodule : ssb_top_bench

// >>> verification/ssb_top_monitor.sv
// port checker for the burst and sleep sram block
// assumes single word transfers on the register bus, one clock
`timescale 1ns/1ns
module ssb_top_monitor
	import ssb_pkg::*;
#(
	parameter int DATA_W = 8
)
(
	input wire logic              i_clock,
	input wire logic              i_sys_rst,
	input wire logic              i_hsel,
	input wire logic [31:0]       i_haddr,
	input wire logic [1:0]        i_htrans,
	input wire logic              i_hwrite,
	input wire logic [31:0]       i_hwdata,
	input wire logic              i_hready,
	input wire logic              i_sleep_request,
	input wire logic              i_sram_select,
	input wire logic              i_sram_write,
	input wire logic              i_burst_advance,
	input wire logic [31:0]       o_hrdata,
	input wire logic              o_hreadyout,
	input wire logic              o_hresp,
	input wire logic [DATA_W-1:0] o_sram_rdata,
	input wire logic              o_sram_rdata_oe
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_sys_rst);
	////////////////////////////////////////////////////////////////
	// shadow of the timing select, so latency is judged per mode
	logic ctrl_wr_reg;
	logic pipe_reg;
	wire  ctrl_hit = i_hsel && i_hready && i_htrans[1] && i_hwrite && (i_haddr == CTRL_OFFSET);
	wire  rd_load  = !i_burst_advance && i_sram_select && !i_sram_write && !i_sleep_request;
	wire  desel    = !i_burst_advance && !i_sram_select && !i_sleep_request;
	always_ff @(posedge i_clock or posedge i_sys_rst)
		if (i_sys_rst)
		begin
			ctrl_wr_reg <= 1'b0;
			pipe_reg    <= CTRL_RESET[CTRL_FLOW_THROUGH_SELECT_BIT];
		end
		else
		begin
			ctrl_wr_reg <= ctrl_hit;
			if (ctrl_wr_reg)
				pipe_reg <= i_hwdata[CTRL_FLOW_THROUGH_SELECT_BIT];
		end
	// bus handshake never stalls and never errors
	AST_READY_HIGH: assert property (o_hreadyout) else $error("ready low");
	AST_RESP_OKAY: assert property (!o_hresp) else $error("error response");
	AST_RDATA_IDLE: assert property (!(i_hsel && i_hready && i_htrans[1] && !i_hwrite)
		|=> o_hrdata == 32'h0) else $error("read data outside read phase");
	AST_SLEEP_FLOAT: assert property (i_sleep_request [*3] |=> !o_sram_rdata_oe)
		else $error("data driven in sleep");
	// still quiet just after wake; request seen high long enough to be asleep
	AST_WAKE_QUIET: assert property ($fell(i_sleep_request) && $past(i_sleep_request, 2)
		&& $past(i_sleep_request, 3)
		|-> !o_sram_rdata_oe ##1 !o_sram_rdata_oe) else $error("driven before wake");
	AST_DESEL_QUIET: assert property (desel [*3] |=> !o_sram_rdata_oe)
		else $error("data after deselect");
	AST_FLOW_LAT: assert property (desel [*2] ##1 (rd_load && !pipe_reg)
		|-> !o_sram_rdata_oe ##1 o_sram_rdata_oe) else $error("flow-through latency");
	AST_PIPE_LAT: assert property (desel [*2] ##1 (rd_load && pipe_reg)
		|=> !o_sram_rdata_oe ##1 o_sram_rdata_oe) else $error("pipelined latency");
	AST_RDATA_HOLD: assert property (!o_sram_rdata_oe |-> $stable(o_sram_rdata))
		else $error("read data changed idle");
	C_SLEEP: cover property (i_sleep_request [*3]);
	C_FLOW: cover property (rd_load && !pipe_reg);
	C_PIPE: cover property (rd_load && pipe_reg);
endmodule : ssb_top_monitor

bind ssb_top ssb_top_monitor #(.DATA_W(DATA_W)) i_ssb_top_monitor (
	.i_clock         (i_clock),
	.i_sys_rst       (i_sys_rst),
	.i_hsel          (i_hsel),
	.i_haddr         (i_haddr),
	.i_htrans        (i_htrans),
	.i_hwrite        (i_hwrite),
	.i_hwdata        (i_hwdata),
	.i_hready        (i_hready),
	.i_sleep_request (i_sleep_request),
	.i_sram_select   (i_sram_select),
	.i_sram_write    (i_sram_write),
	.i_burst_advance (i_burst_advance),
	.o_hrdata        (o_hrdata),
	.o_hreadyout     (o_hreadyout),
	.o_hresp         (o_hresp),
	.o_sram_rdata    (o_sram_rdata),
	.o_sram_rdata_oe (o_sram_rdata_oe)
);
